// ---- gsf_map.svh ----
// register offsets, field positions, reset values and timing counts of the gear select block
`ifndef GSF_MAP_SVH
`define GSF_MAP_SVH

// ****************************************************************
// parameter addresses
// ****************************************************************
`define GSF_ADDR_NUM_FIRST 16'h0278
`define GSF_ADDR_NUM_ALT_A 16'h027A
`define GSF_ADDR_NUM_ALT_B 16'h027C
`define GSF_ADDR_RSVD_A 16'h027E
`define GSF_ADDR_RSVD_B 16'h0280
`define GSF_ADDR_SFLAGS 16'h0282

// ****************************************************************
// reset values and limits
// ****************************************************************
`define GSF_NUM_RESET 32'h0000_0010
`define GSF_NUM_MIN 32'h0000_0001
`define GSF_NUM_MAX 32'h03FF_FFFF
`define GSF_SF_RESET 16'h0000

// ****************************************************************
// special-function field positions
// ****************************************************************
`define GSF_SF_ABN_PULSE_DIS 6
`define GSF_SF_WIRING_ERR_EN 8
`define GSF_SF_WIRING_CUT_EN 9
`define GSF_SF_CLAMP_SEL 10
`define GSF_SF_PULSE_INHIBIT 11
`define GSF_SF_PHASE_LOSS_DIS 12
`define GSF_SF_ENC_OUT_DIS 13

// ****************************************************************
// timing counts
// ****************************************************************
`define GSF_SLEW_STEP 16'h0001

`endif

// ---- gsf_pkg.sv ----
// types and shared helpers of the gear select block
package gsf_pkg;

    typedef enum logic [1:0] {
        GSF_SEL_BASE,
        GSF_SEL_FIRST,
        GSF_SEL_ALT_A,
        GSF_SEL_ALT_B
    } gsf_num_sel_t;

    function automatic logic [15:0] gsf_abs(input logic signed [15:0] v);
        gsf_abs = v[15] ? 16'(-v) : 16'(v);
    endfunction

endpackage

// ---- gsf_slew.sv ----
// rate limiter for the speed command, or direct load
`include "gsf_map.svh"
module gsf_slew #(
    parameter int W = 16,
    parameter logic [W-1:0] STEP = `GSF_SLEW_STEP
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic load,
    input wire logic signed [W-1:0] target,
    output logic signed [W-1:0] out_val
);
    import gsf_pkg::*;

    logic signed [W-1:0] out_reg;
    logic signed [W-1:0] out_next;
    logic signed [W:0] diff;
    logic signed [W:0] step_s;

    always_comb begin
        diff = $signed({target[W-1], target}) - $signed({out_reg[W-1], out_reg});
        step_s = $signed({1'b0, STEP});
        if (load || ((diff <= step_s) && (diff >= -step_s))) begin
            out_next = target;
        end else if (diff > 0) begin
            out_next = W'(out_reg + STEP);
        end else begin
            out_next = W'(out_reg - STEP);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            out_reg <= '0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign out_val = out_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_slew_step;
        !load |=> ($signed({out_reg[W-1], out_reg}) - $signed({$past(out_reg[W-1]), $past(out_reg)})
                   <= $signed({1'b0, STEP}))
               && ($signed({out_reg[W-1], out_reg}) - $signed({$past(out_reg[W-1]), $past(out_reg)})
                   >= -$signed({1'b0, STEP}));
    endproperty
    a_slew_step: assert property (p_slew_step) else $error("ramp step too large");

endmodule // gsf_slew

// ---- gsf_pulse_gate.sv ----
// position pulse gate driven by the limit inputs
module gsf_pulse_gate (
    input wire logic mclk,
    input wire logic srst,
    input wire logic inhibit_en,
    input wire logic position_pulse_mode,
    input wire logic pulse_in,
    input wire logic pulse_dir,
    input wire logic negative_limit_input,
    input wire logic positive_limit_input,
    output logic pulse_out,
    output logic pulse_dir_out
);
    import gsf_pkg::*;

    logic pulse_reg;
    logic pulse_next;
    logic dir_reg;
    logic dir_next;
    logic blocked;

    always_comb begin
        // dir high means positive travel
        blocked = inhibit_en && position_pulse_mode &&
                  (pulse_dir ? positive_limit_input : negative_limit_input);
        pulse_next = pulse_in && !blocked;
        dir_next = pulse_in ? pulse_dir : dir_reg;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pulse_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else begin
            pulse_reg <= pulse_next;
            dir_reg <= dir_next;
        end
    end

    assign pulse_out = pulse_reg;
    assign pulse_dir_out = dir_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_no_inhibit;
        pulse_in && !inhibit_en |=> pulse_out && (pulse_dir_out == $past(pulse_dir));
    endproperty
    a_no_inhibit: assert property (p_no_inhibit) else $error("pulse lost without inhibit");

    property p_same_dir_blocked;
        pulse_in && inhibit_en && position_pulse_mode && pulse_dir && positive_limit_input
            |=> !pulse_out;
    endproperty
    a_same_dir_blocked: assert property (p_same_dir_blocked) else $error("pulse into limit");

    property p_opposite_dir_ok;
        pulse_in && inhibit_en && position_pulse_mode && !pulse_dir && positive_limit_input &&
            !negative_limit_input |=> pulse_out;
    endproperty
    a_opposite_dir_ok: assert property (p_opposite_dir_ok) else $error("pulse away lost");

    property p_both_limits;
        inhibit_en && position_pulse_mode && negative_limit_input && positive_limit_input
            |=> !pulse_out;
    endproperty
    a_both_limits: assert property (p_both_limits) else $error("pulse with both limits");

endmodule // gsf_pulse_gate

// ---- gsf_top.sv ----
// gear numerator selection, special-function flags, zero clamp and pulse inhibit
`include "gsf_map.svh"
module gsf_top #(
    parameter logic [15:0] SLEW_STEP = `GSF_SLEW_STEP
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_addr,
    input wire logic [31:0] par_wdata,
    output logic [31:0] par_rdata,
    output logic par_ack,
    output logic par_err,
    input wire logic numerator_select_bit0,
    input wire logic numerator_select_bit1,
    input wire logic sel0_assigned,
    input wire logic sel1_assigned,
    input wire logic [31:0] base_numerator_setting,
    output logic [31:0] active_numerator,
    output gsf_pkg::gsf_num_sel_t active_sel,
    input wire logic abnormal_pulse_detected,
    input wire logic wiring_error_detected,
    input wire logic wiring_cut_detected,
    input wire logic phase_loss_detected,
    input wire logic encoder_output_detected,
    output logic abnormal_pulse_fault,
    output logic wiring_error_fault,
    output logic wiring_cut_fault,
    output logic phase_loss_fault,
    output logic encoder_output_fault,
    input wire logic speed_mode,
    input wire logic zero_clamp_input,
    input wire logic speed_src_internal,
    input wire logic signed [15:0] speed_cmd_in,
    input wire logic [15:0] clamp_speed_threshold,
    output logic clamp_active,
    output logic position_hold,
    output logic signed [15:0] speed_cmd_out,
    input wire logic position_pulse_mode,
    input wire logic pulse_in,
    input wire logic pulse_dir,
    input wire logic negative_limit_input,
    input wire logic positive_limit_input,
    output logic pulse_out,
    output logic pulse_dir_out
);
    import gsf_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // index 0 first, 1 alt_a, 2 alt_b, 3 none
    function automatic logic [1:0] num_index(input logic [15:0] a);
        case (a)
            `GSF_ADDR_NUM_FIRST: num_index = 2'h0;
            `GSF_ADDR_NUM_ALT_A: num_index = 2'h1;
            `GSF_ADDR_NUM_ALT_B: num_index = 2'h2;
            default: num_index = 2'h3;
        endcase
    endfunction

    function automatic logic num_in_range(input logic [31:0] v);
        num_in_range = (v >= `GSF_NUM_MIN) && (v <= `GSF_NUM_MAX);
    endfunction

    // ****************************************************************
    // parameter registers
    // ****************************************************************
    logic [31:0] num_reg [3];
    logic [31:0] num_next [3];
    logic [15:0] sf_reg;
    logic [15:0] sf_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    logic err_reg;
    logic err_next;
    logic [1:0] widx;
    logic known;
    always_comb begin
        num_next = num_reg;
        sf_next = sf_reg;
        rdata_next = rdata_reg;
        ack_next = par_wr || par_rd;
        err_next = 1'b0;
        widx = num_index(par_addr);
        known = (widx != 2'h3) || (par_addr == `GSF_ADDR_SFLAGS) ||
                (par_addr == `GSF_ADDR_RSVD_A) || (par_addr == `GSF_ADDR_RSVD_B);
        if (par_wr) begin
            if (widx != 2'h3) begin
                if (num_in_range(par_wdata)) begin
                    num_next[widx] = par_wdata;
                end else begin
                    err_next = 1'b1;
                end
            end else if (par_addr == `GSF_ADDR_SFLAGS) begin
                sf_next = par_wdata[15:0];
            end else begin
                err_next = !known;
            end
        end else if (par_rd) begin
            if (widx != 2'h3) begin
                rdata_next = num_reg[widx];
            end else if (par_addr == `GSF_ADDR_SFLAGS) begin
                rdata_next = {16'h0000, sf_reg};
            end else begin
                rdata_next = 32'h0000_0000;
                err_next = !known;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < 3; i++) begin
                num_reg[i] <= `GSF_NUM_RESET;
            end
            sf_reg <= `GSF_SF_RESET;
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            num_reg <= num_next;
            sf_reg <= sf_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
        end
    end
    assign par_rdata = rdata_reg;
    assign par_ack = ack_reg;
    assign par_err = err_reg;

    // ****************************************************************
    // gear numerator selection
    // ****************************************************************
    gsf_num_sel_t sel_reg;
    gsf_num_sel_t sel_next;
    logic [31:0] anum_reg;
    logic [31:0] anum_next;
    always_comb begin
        // an unassigned select input counts as low
        if (!sel0_assigned && !sel1_assigned) begin
            sel_next = GSF_SEL_BASE;
        end else begin
            case ({sel1_assigned && numerator_select_bit1, sel0_assigned && numerator_select_bit0})
                2'b00: sel_next = GSF_SEL_BASE;
                2'b01: sel_next = GSF_SEL_FIRST;
                2'b10: sel_next = GSF_SEL_ALT_A;
                default: sel_next = GSF_SEL_ALT_B;
            endcase
        end
        case (sel_next)
            GSF_SEL_FIRST: anum_next = num_reg[0];
            GSF_SEL_ALT_A: anum_next = num_reg[1];
            GSF_SEL_ALT_B: anum_next = num_reg[2];
            default: anum_next = base_numerator_setting;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            sel_reg <= GSF_SEL_BASE;
            anum_reg <= `GSF_NUM_RESET;
        end else begin
            sel_reg <= sel_next;
            anum_reg <= anum_next;
        end
    end
    assign active_sel = sel_reg;
    assign active_numerator = anum_reg;

    // ****************************************************************
    // fault detector gating
    // ****************************************************************
    logic [4:0] flt_reg;
    logic [4:0] flt_next;
    always_comb begin
        flt_next[0] = abnormal_pulse_detected && !sf_reg[`GSF_SF_ABN_PULSE_DIS];
        flt_next[1] = wiring_error_detected && sf_reg[`GSF_SF_WIRING_ERR_EN];
        flt_next[2] = wiring_cut_detected && sf_reg[`GSF_SF_WIRING_CUT_EN];
        flt_next[3] = phase_loss_detected && !sf_reg[`GSF_SF_PHASE_LOSS_DIS];
        flt_next[4] = encoder_output_detected && !sf_reg[`GSF_SF_ENC_OUT_DIS];
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            flt_reg <= 5'h00;
        end else begin
            flt_reg <= flt_next;
        end
    end
    assign abnormal_pulse_fault = flt_reg[0];
    assign wiring_error_fault = flt_reg[1];
    assign wiring_cut_fault = flt_reg[2];
    assign phase_loss_fault = flt_reg[3];
    assign encoder_output_fault = flt_reg[4];

    // ****************************************************************
    // zero clamp
    // ****************************************************************
    logic clamp_cond;
    logic clamp_sel;
    logic clamp_reg;
    logic clamp_next;
    logic hold_reg;
    logic hold_next;
    logic slew_load;
    logic signed [15:0] slew_target;
    always_comb begin
        clamp_sel = sf_reg[`GSF_SF_CLAMP_SEL];
        clamp_cond = speed_mode && zero_clamp_input &&
                     (gsf_abs(speed_cmd_in) < clamp_speed_threshold);
        clamp_next = clamp_cond;
        hold_next = clamp_cond && !clamp_sel;
        slew_target = (clamp_cond && clamp_sel) ? 16'sh0000 : speed_cmd_in;
        // only the analog source with bit 10 set is ramped here
        slew_load = !(clamp_sel && !speed_src_internal);
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            clamp_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            clamp_reg <= clamp_next;
            hold_reg <= hold_next;
        end
    end
    assign clamp_active = clamp_reg;
    assign position_hold = hold_reg;

    gsf_slew #(
        .W(16),
        .STEP(SLEW_STEP)
    ) u_slew (
        .mclk(mclk),
        .srst(srst),
        .load(slew_load),
        .target(slew_target),
        .out_val(speed_cmd_out)
    );

    gsf_pulse_gate u_gate (
        .mclk(mclk),
        .srst(srst),
        .inhibit_en(sf_reg[`GSF_SF_PULSE_INHIBIT]),
        .position_pulse_mode(position_pulse_mode),
        .pulse_in(pulse_in),
        .pulse_dir(pulse_dir),
        .negative_limit_input(negative_limit_input),
        .positive_limit_input(positive_limit_input),
        .pulse_out(pulse_out),
        .pulse_dir_out(pulse_dir_out)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_sel_base;
        !sel0_assigned && !sel1_assigned |=> active_numerator == $past(base_numerator_setting);
    endproperty
    a_sel_base: assert property (p_sel_base) else $error("base numerator not used");
    property p_sel_alt_b;
        sel0_assigned && sel1_assigned && numerator_select_bit0 && numerator_select_bit1
            |=> active_numerator == $past(num_reg[2]) && active_sel == GSF_SEL_ALT_B;
    endproperty
    a_sel_alt_b: assert property (p_sel_alt_b) else $error("wrong numerator selected");
    property p_num_range;
        num_in_range(num_reg[0]) && num_in_range(num_reg[1]) && num_in_range(num_reg[2]);
    endproperty
    a_num_range: assert property (p_num_range) else $error("numerator out of range");
    sequence s_sf_write;
        par_wr && par_addr == `GSF_ADDR_SFLAGS;
    endsequence
    sequence s_sf_read;
        !par_wr && par_rd && par_addr == `GSF_ADDR_SFLAGS;
    endsequence
    property p_sf_readback;
        s_sf_write ##1 s_sf_read |=> par_ack && par_rdata == {16'h0000, $past(par_wdata[15:0], 2)};
    endproperty
    a_sf_readback: assert property (p_sf_readback) else $error("flags readback mismatch");
    property p_abn_disabled;
        abnormal_pulse_detected && sf_reg[`GSF_SF_ABN_PULSE_DIS] |=> !abnormal_pulse_fault;
    endproperty
    a_abn_disabled: assert property (p_abn_disabled) else $error("abnormal pulse not masked");
    property p_wiring_err;
        wiring_error_detected |=> wiring_error_fault == $past(sf_reg[`GSF_SF_WIRING_ERR_EN]);
    endproperty
    a_wiring_err: assert property (p_wiring_err) else $error("wiring error gate wrong");
    property p_wiring_cut;
        wiring_cut_detected |=> wiring_cut_fault == $past(sf_reg[`GSF_SF_WIRING_CUT_EN]);
    endproperty
    a_wiring_cut: assert property (p_wiring_cut) else $error("wiring cut gate wrong");
    property p_phase_loss;
        phase_loss_detected && !sf_reg[`GSF_SF_PHASE_LOSS_DIS] |=> phase_loss_fault;
    endproperty
    a_phase_loss: assert property (p_phase_loss) else $error("phase loss not reported");
    property p_enc_out;
        encoder_output_detected |=> encoder_output_fault != $past(sf_reg[`GSF_SF_ENC_OUT_DIS]);
    endproperty
    a_enc_out: assert property (p_enc_out) else $error("encoder fault gate wrong");
    property p_clamp_cause;
        clamp_active |-> $past(speed_mode && zero_clamp_input);
    endproperty
    a_clamp_cause: assert property (p_clamp_cause) else $error("clamp without cause");
    property p_hold;
        clamp_cond && !clamp_sel |=> position_hold && clamp_active;
    endproperty
    a_hold: assert property (p_hold) else $error("position not held");
    property p_force_zero;
        clamp_cond && clamp_sel && speed_src_internal |=> speed_cmd_out == 16'sh0000;
    endproperty
    a_force_zero: assert property (p_force_zero) else $error("speed not forced to zero");
endmodule // gsf_top

// ---- gsf_pulse_src.sv ----
// pulse command source model for the gear select bench
module gsf_pulse_src (
    input wire logic mclk,
    input wire logic go,
    input wire logic dir,
    output logic pulse_in,
    output logic pulse_dir
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // one-cycle step pulse, direction line toggles while idle
    // ****
    initial begin
        pulse_in = 1'h0;
        pulse_dir = 1'h0;
    end
    always @(posedge mclk) begin
        pulse_in <= go;
        pulse_dir <= go ? dir : ~pulse_dir;
    end
endmodule // gsf_pulse_src

// ---- gsf_tb.sv ----
// self-checking bench for the gear select block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import gsf_pkg::*;
    localparam logic [15:0] STEP = 16'h0004;
    localparam logic [31:0] Z = 32'h0;
    logic mclk = 1'h0, srst = 1'h1, par_wr = 1'h0, par_rd = 1'h0, par_ack, par_err;
    logic [15:0] par_addr = 16'h0, thr = 16'h0064, f;
    logic [31:0] par_wdata = Z, base = 32'hABCD, par_rdata, act_num;
    logic s0 = 1'h0, s1 = 1'h0, a0 = 1'h0, a1 = 1'h0, spd = 1'h0, zci = 1'h0, intl = 1'h0;
    logic go = 1'h0, dir = 1'h0, nl = 1'h0, pl = 1'h0, ppm = 1'h1;
    logic clamp, hold, pulse_in, pulse_dir, pout, pdout;
    logic [4:0] det = 5'h0;
    wire [4:0] flt;
    logic signed [15:0] cmd = 16'sh0, sout;
    gsf_num_sel_t act_sel;
    int err_count = 0, checks_done = 0;

    always #12.5 mclk = ~mclk;

    gsf_pulse_src i_src (.mclk, .go, .dir, .pulse_in, .pulse_dir);
    gsf_top #(.SLEW_STEP(STEP)) i_dut (
        .mclk, .srst, .par_wr, .par_rd, .par_addr, .par_wdata, .par_rdata, .par_ack, .par_err,
        .numerator_select_bit0(s0), .numerator_select_bit1(s1), .sel0_assigned(a0),
        .sel1_assigned(a1), .base_numerator_setting(base), .active_numerator(act_num),
        .active_sel(act_sel), .abnormal_pulse_detected(det[4]), .wiring_error_detected(det[3]),
        .wiring_cut_detected(det[2]), .phase_loss_detected(det[1]),
        .encoder_output_detected(det[0]), .abnormal_pulse_fault(flt[4]),
        .wiring_error_fault(flt[3]), .wiring_cut_fault(flt[2]), .phase_loss_fault(flt[1]),
        .encoder_output_fault(flt[0]), .speed_mode(spd), .zero_clamp_input(zci),
        .speed_src_internal(intl), .speed_cmd_in(cmd), .clamp_speed_threshold(thr),
        .clamp_active(clamp), .position_hold(hold), .speed_cmd_out(sout),
        .position_pulse_mode(ppm), .pulse_in, .pulse_dir, .negative_limit_input(nl),
        .positive_limit_input(pl), .pulse_out(pout), .pulse_dir_out(pdout)
    );

    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic e);
        int n;
        n = 0;
        @(posedge mclk);
        {par_wr, par_rd} <= {w, ~w};
        par_addr <= a;
        par_wdata <= d;
        @(posedge mclk);
        {par_wr, par_rd} <= 2'h0;
        do begin
            @(negedge mclk);
            n++;
        end while (par_ack !== 1'h1 && n < 4);
        if (par_ack !== 1'h1) begin
            err_count++;
            summarize();
        end
        chk(par_err, e);
        if (!w) chk(par_rdata, exp);
    endtask

    task automatic cl(input logic m, input logic z, input logic n, input logic signed [15:0] c);
        @(posedge mclk);
        {spd, zci, intl} <= {m, z, n};
        cmd <= c;
        step(1);
    endtask

    task automatic pulse(input logic d, input logic e);
        @(posedge mclk);
        {go, dir} <= {1'h1, d};
        @(posedge mclk);
        go <= 1'h0;
        step(1);
        chk(pout, e);
        if (e) chk(pdout, d);
    endtask

    // ****
    // tests
    // ****
    initial begin
        #2500000;
        err_count++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'h0;
        acc(0, 16'h027A, Z, 32'h10, 0);
        acc(0, 16'h027C, Z, 32'h10, 0);
        acc(0, 16'h0282, Z, Z, 0);
        acc(1, 16'h027A, Z, Z, 1);
        acc(1, 16'h027C, 32'h0400_0000, Z, 1);
        acc(0, 16'h027A, Z, 32'h10, 0);
        acc(1, 16'h027A, 32'h1, Z, 0);
        acc(1, 16'h027C, 32'h03FF_FFFF, Z, 0);
        acc(1, 16'h0278, 32'h1234, Z, 0);
        acc(0, 16'h027C, Z, 32'h03FF_FFFF, 0);
        acc(1, 16'h0282, 32'hC083, Z, 0);
        acc(0, 16'h0282, Z, 32'hC083, 0);
        acc(1, 16'h027E, 32'h55, Z, 0);
        acc(0, 16'h027E, Z, Z, 0);
        acc(0, 16'h0300, Z, Z, 1);
        // write then read the flags on consecutive edges
        @(posedge mclk);
        {par_wr, par_rd, par_addr, par_wdata} <= {2'h2, 16'h0282, 32'h0000_0800};
        @(posedge mclk);
        {par_wr, par_rd} <= 2'h1;
        @(posedge mclk);
        par_rd <= 1'h0;
        step(0);
        chk({par_ack, par_rdata}, {1'h1, 32'h0000_0800});
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            {a1, a0, s1, s0} <= {2'h3, i[1:0]};
            step(1);
            chk(act_num, i == 0 ? base : i == 1 ? 32'h1234 : i == 2 ? 32'h1 : 32'h03FF_FFFF);
            chk(act_sel, i[1:0]);
        end
        @(posedge mclk);
        a1 <= 1'h0;
        step(1);
        chk(act_num, 32'h1234);
        @(posedge mclk);
        a0 <= 1'h0;
        step(1);
        chk(act_num, base);
        $display("test selection done");
        for (int i = 0; i < 4; i++) begin
            f = i == 0 ? 16'h0 : i == 1 ? 16'h3340 : i == 2 ? 16'h1100 : 16'h2240;
            acc(1, 16'h0282, {16'h0, f}, Z, 0);
            @(posedge mclk);
            det <= 5'h1F;
            step(1);
            chk(flt, {~f[6], f[8], f[9], ~f[12], ~f[13]});
            @(posedge mclk);
            det <= 5'h00;
            step(1);
            chk(flt, 5'h00);
        end
        $display("test faults done");
        acc(1, 16'h0282, 32'h0400, Z, 0);
        cl(1, 0, 1, 16'sh0032);
        chk({clamp, hold, sout}, {2'h0, 16'h0032});
        cl(1, 1, 1, 16'sh0032);
        chk({clamp, hold, sout}, {2'h2, 16'h0});
        cl(1, 1, 1, 16'sh0064);
        chk(clamp, 1'h0);
        cl(0, 1, 1, 16'sh0032);
        chk(clamp, 1'h0);
        acc(1, 16'h0282, Z, Z, 0);
        cl(1, 1, 1, 16'sh0032);
        chk({clamp, hold, sout}, {2'h3, 16'h0032});
        cl(1, 1, 0, 16'sh0032);
        chk({hold, sout}, {1'h1, 16'h0032});
        acc(1, 16'h0282, 32'h0400, Z, 0);
        step(1);
        chk(sout > 0 && sout < 16'sh0032, 1'h1);
        step(20);
        chk(sout, Z);
        cl(1, 0, 0, -16'sh0014);
        chk(sout > -16'sh0014, 1'h1);
        step(10);
        chk(sout, cmd);
        $display("test clamp done");
        for (int i = 0; i < 32; i++) begin
            acc(1, 16'h0282, {20'h0, i[4], 11'h0}, Z, 0);
            @(posedge mclk);
            {ppm, nl, pl} <= i[3:1];
            pulse(i[0], !(i[4] & i[3] & (i[0] ? i[1] : i[2])));
        end
        $display("test pulses done");
        summarize();
    end
endmodule // testbench
